// File: rtl/vcp_palette.sv
// vcp_palette: dual palette with index/data register port and pixel lookup
`timescale 1ns/1ps

// Functional notes
// - Two separate palettes are kept, one per display pipe, and register accesses pick one.
// - Each palette holds 256 three-byte entries selected by an 8-bit index.
// - Successive data port reads return red, then green, then blue of the read entry.
// - After the blue byte is read the read index increments.
// - Data port writes deliver red, green, blue and the entry is updated only after blue.
// - After the blue byte is written the write index increments.
// - Zeroing an index then 768 data accesses walks the whole palette in order.
// - The lookup index is the pixel mask ANDed with the frame buffer pixel.
// - Port state reads 00 after a write index write and 11 after a read index write.
// - Writing the read index aborts an unfinished write sequence without commit.
// - Writing either index resets the byte sequencer to red.
// - Palette access stays usable in every display mode.
// - A write and a lookup hitting the same entry together give the previous pixel value.
module vcp_palette
  import vcp_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  srst_i,
  // register port
  input  wire logic [vcp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic [vcp_pkg::BYTE_W-1:0] wdata_i,
  input  wire logic                  pal_sel_i,
  output logic [vcp_pkg::BYTE_W-1:0] rdata_o,
  // display side, one lookup per pipe
  input  wire logic [vcp_pkg::PIPE_COUNT-1:0] pix_valid_i,
  input  wire logic [vcp_pkg::PIPE_COUNT*8-1:0] pix_data_i,
  output logic [vcp_pkg::PIPE_COUNT*24-1:0] rgb_o
);
  import vcp_pkg::*;

  // one helper for decoding strobed addresses
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [23:0] pal_mem [PIPE_COUNT][ENTRY_COUNT];

  logic [IDX_W-1:0]  rd_ptr_r, rd_ptr_nxt;
  logic [IDX_W-1:0]  wr_ptr_r, wr_ptr_nxt;
  vcp_phase_t        phase_r, phase_nxt;
  logic [1:0]        state_r, state_nxt;
  logic [7:0]        mask_r, mask_nxt;
  logic [7:0]        red_r, red_nxt, grn_r, grn_nxt;
  logic [7:0]        rdata_r, rdata_nxt;
  logic              commit;
  logic [23:0]       rd_entry;

  wire logic wr_rx   = wr_i && hit(addr_i, OFS_RD_POINTER);
  wire logic wr_wx   = wr_i && hit(addr_i, OFS_WR_POINTER);
  wire logic wr_data = wr_i && hit(addr_i, OFS_BYTE_PORT);
  wire logic rd_data = rd_i && hit(addr_i, OFS_BYTE_PORT);

  assign rd_entry = pal_mem[pal_sel_i][rd_ptr_r];

  // sequencer, pointers, staging; index writes take priority over data accesses
  always_comb
  begin
    rd_ptr_nxt = rd_ptr_r;
    wr_ptr_nxt = wr_ptr_r;
    phase_nxt  = phase_r;
    state_nxt  = state_r;
    mask_nxt   = mask_r;
    red_nxt    = red_r;
    grn_nxt    = grn_r;
    rdata_nxt  = rdata_r;
    commit     = 1'b0;
    if (wr_i && hit(addr_i, OFS_PIXEL_MASK))
      mask_nxt = wdata_i;
    if (wr_rx)
    begin
      rd_ptr_nxt = wdata_i;
      phase_nxt  = VCP_RED;         // staged bytes dropped, no commit
      state_nxt  = STATE_RD_LAST;
    end
    else if (wr_wx)
    begin
      wr_ptr_nxt = wdata_i;
      phase_nxt  = VCP_RED;
      state_nxt  = STATE_WR_LAST;
    end
    else if (wr_data)
    begin
      case (phase_r)
        VCP_RED:   begin red_nxt = wdata_i; phase_nxt = VCP_GREEN; end
        VCP_GREEN: begin grn_nxt = wdata_i; phase_nxt = VCP_BLUE;  end
        VCP_BLUE:
        begin
          commit     = 1'b1;
          wr_ptr_nxt = wr_ptr_r + 8'h01;
          phase_nxt  = VCP_RED;
        end
        default:   phase_nxt = VCP_RED;
      endcase
    end
    else if (rd_data)
    begin
      case (phase_r)
        VCP_RED:   begin rdata_nxt = rd_entry[23:16]; phase_nxt = VCP_GREEN; end
        VCP_GREEN: begin rdata_nxt = rd_entry[15:8];  phase_nxt = VCP_BLUE;  end
        VCP_BLUE:
        begin
          rdata_nxt  = rd_entry[7:0];
          rd_ptr_nxt = rd_ptr_r + 8'h01;
          phase_nxt  = VCP_RED;
        end
        default:   phase_nxt = VCP_RED;
      endcase
    end
    // pixel mask and read index offset reads return register views, other non-data reads keep rdata; access never depends on display mode
    if (rd_i && hit(addr_i, OFS_PIXEL_MASK))
      rdata_nxt = mask_r;
    else if (rd_i && hit(addr_i, OFS_RD_POINTER))
      rdata_nxt = {6'h00, state_r};
  end

  // register the port state
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rd_ptr_r <= RST_POINTER;
      wr_ptr_r <= RST_POINTER;
      phase_r  <= VCP_RED;
      state_r  <= STATE_WR_LAST;
      mask_r   <= RST_PIXEL_MASK;
      red_r    <= 8'h00;
      grn_r    <= 8'h00;
      rdata_r  <= 8'h00;
    end
    else
    begin
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      phase_r  <= phase_nxt;
      state_r  <= state_nxt;
      mask_r   <= mask_nxt;
      red_r    <= red_nxt;
      grn_r    <= grn_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // palette storage has no reset; contents are undefined until loaded
  always_ff @(posedge clock_i)
  begin
    if (commit)
      pal_mem[pal_sel_i][wr_ptr_r] <= {red_r, grn_r, wdata_i};
  end

  assign rdata_o = rdata_r;

  // per-pipe lookup with anti-sparkle hold
  genvar p;
  generate
    for (p = 0; p < PIPE_COUNT; p++)
    begin : g_pipe
      logic [7:0]  look_idx;
      logic        collide;
      logic [23:0] rgb_r, rgb_nxt;
      assign look_idx = pix_data_i[p*8 +: 8] & mask_r;
      assign collide  = commit && (pal_sel_i == 1'(p)) && (wr_ptr_r == look_idx);
      // a colliding lookup keeps the last pixel so mid-write data never shows
      always_comb
      begin
        rgb_nxt = rgb_r;
        if (pix_valid_i[p] && !collide)
          rgb_nxt = pal_mem[p][look_idx];
      end
      always_ff @(posedge clock_i)
      begin
        if (srst_i)
          rgb_r <= 24'h000000;
        else
          rgb_r <= rgb_nxt;
      end
      assign rgb_o[p*24 +: 24] = rgb_r;

      a_sparkle_hold: assert property (@(posedge clock_i) disable iff (srst_i)
        (pix_valid_i[p] && collide) |=> $stable(rgb_o[p*24 +: 24]))
        else $error("colliding lookup changed pixel");
      a_mask_lookup: assert property (@(posedge clock_i) disable iff (srst_i)
        (pix_valid_i[p] && !collide) |=> rgb_o[p*24 +: 24] == $past(pal_mem[p][look_idx]))
        else $error("lookup value mismatch");
    end
  endgenerate

  // checks on the port sequencer
  // host spaces its writes by one idle cycle; a data access or index write in a gap would move the sequencer
  sequence s_three_writes;
    wr_data ##1 !(wr_i || rd_i) ##1 wr_data ##1 !(wr_i || rd_i) ##1 wr_data;
  endsequence

  a_idx_resets_seq: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_rx || wr_wx) |=> phase_r == VCP_RED)
    else $error("index write did not reset sequencer");
  a_state_read: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_rx |=> state_r == STATE_RD_LAST)
    else $error("state not 11 after read index write");
  a_state_write: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_wx && !wr_rx) |=> state_r == STATE_WR_LAST)
    else $error("state not 00 after write index write");
  a_commit_blue: assert property (@(posedge clock_i) disable iff (srst_i)
    commit |-> (phase_r == VCP_BLUE && wr_data && !wr_rx && !wr_wx))
    else $error("commit without blue byte");
  a_abort_write: assert property (@(posedge clock_i) disable iff (srst_i)
    wr_rx |-> !commit)
    else $error("read index write committed entry");
  a_wr_ptr_step: assert property (@(posedge clock_i) disable iff (srst_i)
    commit |=> wr_ptr_r == $past(wr_ptr_r) + 8'h01)
    else $error("write index did not step");
  a_rd_ptr_step: assert property (@(posedge clock_i) disable iff (srst_i)
    (rd_data && !wr_i && phase_r == VCP_BLUE) |=> rd_ptr_r == $past(rd_ptr_r) + 8'h01)
    else $error("read index did not step");
  a_write_triple: assert property (@(posedge clock_i) disable iff (srst_i)
    (phase_r == VCP_RED && !wr_rx && !wr_wx) ##0 s_three_writes |-> commit)
    else $error("three writes gave no commit");
  a_read_order: assert property (@(posedge clock_i) disable iff (srst_i)
    (rd_data && !wr_i && phase_r == VCP_GREEN) |=> rdata_o == $past(rd_entry[15:8]))
    else $error("green byte out of order");

endmodule // vcp_palette

// File: rtl/vcp_pkg.sv
// vcp_pkg: shared constants for the colour palette access block
package vcp_pkg;
  localparam int unsigned PIPE_COUNT    = 2;
  localparam int unsigned ENTRY_COUNT   = 256;
  localparam int unsigned IDX_W         = 8;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned ADDR_W        = 10;
  // register port offsets
  localparam logic [9:0]  OFS_PIXEL_MASK  = 10'h3C6;
  localparam logic [9:0]  OFS_RD_POINTER  = 10'h3C7;  // write side; read side is port state
  localparam logic [9:0]  OFS_WR_POINTER  = 10'h3C8;
  localparam logic [9:0]  OFS_BYTE_PORT   = 10'h3C9;
  // reset values and port state codes
  localparam logic [7:0]  RST_POINTER     = 8'h00;
  localparam logic [7:0]  RST_PIXEL_MASK  = 8'hFF;
  localparam logic [1:0]  STATE_WR_LAST   = 2'h0;
  localparam logic [1:0]  STATE_RD_LAST   = 2'h3;
  localparam int unsigned STATE_LO        = 0;
  localparam int unsigned STATE_HI        = 1;
  // colour byte sequencer
  typedef enum logic [1:0] {
    VCP_RED   = 2'b00,
    VCP_GREEN = 2'b01,
    VCP_BLUE  = 2'b10
  } vcp_phase_t;
endpackage : vcp_pkg

// File: bench/vcp_host_model.sv
// vcp_host_model: host side of the palette register port
`timescale 1ns/1ps
module vcp_host_model
  import vcp_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic [vcp_pkg::BYTE_W-1:0] rdata_i,
  output logic [vcp_pkg::ADDR_W-1:0]      addr_o = '0,
  output logic                           wr_o = 1'b0,
  output logic                           rd_o = 1'b0,
  output logic [vcp_pkg::BYTE_W-1:0]      wdata_o = '0,
  output logic                           sel_o = 1'b0
);
  // released lines show the inverse, so a stale address never passes
  task automatic put(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  // one read strobe per call; the data is sampled 1 ns after the edge that takes the strobe
  task automatic get(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  task automatic pick(input logic s);
    @(posedge clock_i);
    sel_o <= s;
  endtask
endmodule // vcp_host_model

// File: bench/vga_color_palette_access_test.sv
// vga_color_palette_access_test: register port and lookup tests
`timescale 1ns/1ps
module vga_color_palette_access_test;
  import vcp_pkg::*;
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic [9:0]  addr;
  logic        wr;
  logic        rd;
  logic        sel;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [1:0]  pix_valid = '0;
  logic [15:0] pix_data = '0;
  logic [47:0] rgb;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  always #50 clock_i = ~clock_i;
  vcp_palette dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr), .wr_i(wr),
    .rd_i(rd), .wdata_i(wdata), .pal_sel_i(sel), .rdata_o(rdata),
    .pix_valid_i(pix_valid), .pix_data_i(pix_data), .rgb_o(rgb));
  vcp_host_model host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .sel_o(sel));
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    total_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] want);
    logic [7:0] d;
    host.get(a, d);
    chk({16'h0, d}, {16'h0, want});
  endtask
  task automatic entry(input logic [7:0] ix, input logic [23:0] c);
    host.put(OFS_WR_POINTER, ix);
    for (int j = 2; j >= 0; j--)
      host.put(OFS_BYTE_PORT, c[j*8+:8]);
  endtask
  task automatic rd_ent(input logic [7:0] ix, input logic [23:0] c);
    host.put(OFS_RD_POINTER, ix);
    for (int j = 2; j >= 0; j--)
      rd_chk(OFS_BYTE_PORT, c[j*8+:8]);
  endtask
  // lookup answer lands one cycle after the valid edge
  task automatic look(input int p, input logic [7:0] px, input logic [23:0] want);
    @(posedge clock_i);
    pix_valid[p] <= 1'b1;
    pix_data[p*8+:8] <= px;
    @(posedge clock_i);
    pix_valid <= '0;
    pix_data <= ~pix_data;
    #1;
    chk(rgb[p*24+:24], want);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard: the tests need about 3200 cycles
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    rd_chk(OFS_RD_POINTER, 8'h00);
    // write-only and unmapped reads leave the last read byte standing
    rd_chk(OFS_WR_POINTER, 8'h00);
    rd_chk(10'h100, 8'h00);
    rd_chk(OFS_PIXEL_MASK, RST_PIXEL_MASK);
    host.put(OFS_WR_POINTER, 8'h00);
    for (int i = 0; i < 768; i++)
      host.put(OFS_BYTE_PORT, i[7:0] ^ 8'hA5);
    host.put(OFS_RD_POINTER, 8'h00);
    for (int i = 0; i < 768; i++)
      rd_chk(OFS_BYTE_PORT, i[7:0] ^ 8'hA5);
    // both pointers wrapped to entry 0
    for (int j = 0; j < 3; j++)
      host.put(OFS_BYTE_PORT, 8'h40 + j[7:0]);
    rd_ent(8'h00, 24'h404142);
    $display("test walk done");
    entry(8'h05, 24'h112233);
    host.put(OFS_WR_POINTER, 8'h05);
    host.put(OFS_BYTE_PORT, 8'hEE);
    host.put(OFS_BYTE_PORT, 8'hEE);
    host.put(OFS_RD_POINTER, 8'h05);
    rd_chk(OFS_RD_POINTER, {6'h00, STATE_RD_LAST});
    rd_ent(8'h05, 24'h112233);
    host.put(OFS_WR_POINTER, 8'h06);
    rd_chk(OFS_RD_POINTER, {6'h00, STATE_WR_LAST});
    host.put(OFS_BYTE_PORT, 8'hEE);
    entry(8'h07, 24'hABCDEF);
    rd_ent(8'h07, 24'hABCDEF);
    $display("test abort done");
    host.put(OFS_PIXEL_MASK, 8'h0F);
    rd_chk(OFS_PIXEL_MASK, 8'h0F);
    host.pick(1'b1);
    entry(8'h05, 24'h445566);
    look(1, 8'hF5, 24'h445566);
    look(0, 8'hF5, 24'h112233);
    host.put(OFS_WR_POINTER, 8'h05);
    host.put(OFS_BYTE_PORT, 8'h77);
    host.put(OFS_BYTE_PORT, 8'h88);
    fork
      host.put(OFS_BYTE_PORT, 8'h99);
      look(1, 8'h05, 24'h445566);
    join
    look(1, 8'h05, 24'h778899);
    $display("test lookup done");
    give_verdict();
  end
endmodule // vga_color_palette_access_test
